// ===== bench/cfgwd_decoder_sva.sv
`default_nettype none
module cfgwd_decoder_sva (
  input wire logic        clk, sys_rst, clkEn, byteValid, frameStart, writeDonePulse,
  input wire logic [7:0]  byteData, sweepBehaviourCfg,
  input wire logic        reinitDefaultPulse, reinitKeepPulse, activityLedOn,
  input wire logic        ch1SweepMode, ch2SweepMode, rewindAfterCycles,
  input wire logic [39:0] sweepStartHz, sweepStopHz, sweepIncrementHz,
  input wire logic [31:0] pointHoldTime, sweepRepeatCount,
  input wire logic [15:0] tablePointCount
);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Command byte and one data byte
  sequence cmd(logic [7:0] a); clkEn && byteValid && frameStart && byteData == a; endsequence
  sequence dat; clkEn && byteValid && !frameStart; endsequence
  a_rewind_bit5: assert property (cmd(8'h06) ##1 dat
    |=> sweepBehaviourCfg == $past(byteData) && rewindAfterCycles == sweepBehaviourCfg[5])
    else $error("rewind flag differs from bit 5");
  a_freeze_hold: assert property (!clkEn |=> $stable({writeDonePulse,
    reinitDefaultPulse, reinitKeepPulse, activityLedOn, ch1SweepMode, ch2SweepMode,
    sweepBehaviourCfg, sweepStartHz, sweepStopHz, sweepIncrementHz, pointHoldTime,
    sweepRepeatCount, tablePointCount})) else $error("state moved while enable low");
  a_done_single: assert property (writeDonePulse && clkEn |=> !writeDonePulse)
    else $error("done pulse longer than one cycle");
  a_reinit_default: assert property (cmd(8'h01) ##1 dat ##0 byteData == 8'h01
    |=> reinitDefaultPulse && writeDonePulse) else $error("no default reinit pulse");
  a_reinit_keep: assert property (cmd(8'h01) ##1 dat ##0 byteData == 8'h00
    |=> reinitKeepPulse && !reinitDefaultPulse) else $error("no keep reinit pulse");
  a_led_on: assert property (cmd(8'h02) ##1 dat ##0 byteData == 8'h01
    |=> activityLedOn) else $error("activity led not set");
  a_mode_ch2: assert property (cmd(8'h05) ##1 dat ##0 byteData[1:0] == 2'b11
    |=> ch2SweepMode && $stable(ch1SweepMode)) else $error("mode went to wrong channel");
  a_quiet_regs: assert property ($changed({sweepStartHz, sweepStopHz,
    sweepIncrementHz, pointHoldTime, sweepRepeatCount, tablePointCount}) |-> writeDonePulse)
    else $error("register changed without a write");
  a_start_word: assert property (cmd(8'h07) ##1 dat [*5] |=> sweepStartHz == {
    $past(byteData, 5), $past(byteData, 4), $past(byteData, 3), $past(byteData, 2),
    $past(byteData)}) else $error("start word assembled wrong");
  a_points_word: assert property (cmd(8'h0c) ##1 dat [*2]
    |=> tablePointCount == {$past(byteData, 2), $past(byteData)}) else $error("bad count");
endmodule // cfgwd_decoder_sva
bind cfgwd_decoder cfgwd_decoder_sva cfgwd_decoder_sva_inst (.*);
`default_nettype wire

// ===== bench/cfgwd_host.sv
`default_nettype none
module cfgwd_host (
  input  wire logic       clk,
  output logic            vld,
  output logic [7:0]      dat,
  output logic            fs
);
  timeunit 1ns; timeprecision 1ns;
  initial begin
    vld = 1'b0; dat = 8'h00; fs = 1'b0;
  end
  // Command byte with frame mark, then only n data bytes, MSB first
  task automatic wr(input logic [7:0] a, input logic [39:0] d, input int n);
    @(negedge clk); vld = 1'b1; fs = 1'b1; dat = a;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk); fs = 1'b0; dat = d[i*8 +: 8];
    end
    @(negedge clk); vld = 1'b0; dat = ~dat;
  endtask
endmodule // cfgwd_host
`default_nettype wire

// ===== bench/test_config_register_write_decoder.sv
`default_nettype none
module test_config_register_write_decoder;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, vld, fs, rd, rk, led, m1, m2, rw, done;
  logic [7:0] dat, cfg;
  logic [39:0] st, sp, inc;
  logic [31:0] hold, rep;
  logic [15:0] pts;
  int err_total = 0, cmp_count = 0;
  // Clock
  always #50 clk = ~clk;
  cfgwd_host cfgwd_host_inst (.clk(clk), .vld(vld), .dat(dat), .fs(fs));
  cfgwd_decoder cfgwd_decoder_inst (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .byteValid(vld), .byteData(dat), .frameStart(fs), .reinitDefaultPulse(rd),
    .reinitKeepPulse(rk), .activityLedOn(led), .ch1SweepMode(m1), .ch2SweepMode(m2),
    .sweepBehaviourCfg(cfg), .rewindAfterCycles(rw), .sweepStartHz(st), .sweepStopHz(sp),
    .sweepIncrementHz(inc), .pointHoldTime(hold), .sweepRepeatCount(rep),
    .tablePointCount(pts), .writeDonePulse(done));
  task automatic chk(input logic [39:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Five-byte frequency words
  task automatic t_freq;
    cfgwd_host_inst.wr(8'h07, 40'h12_3456_789a, 5);
    chk(st, 40'h12_3456_789a);
    cfgwd_host_inst.wr(8'h08, 40'hfe_dcba_9876, 5);
    chk(sp, 40'hfe_dcba_9876);
    cfgwd_host_inst.wr(8'h09, 40'h00_0000_0001, 5);
    chk(inc, 40'h1);
    chk(done, 1'b1);
    $display("t_freq done");
  endtask
  // Four- and two-byte words
  task automatic t_words;
    cfgwd_host_inst.wr(8'h0a, 40'h8765_4321, 4);
    chk(hold, 40'h8765_4321);
    cfgwd_host_inst.wr(8'h0b, 40'h0000_0003, 4);
    chk(rep, 40'h3);
    cfgwd_host_inst.wr(8'h0c, 40'hbeef, 2);
    chk(pts, 40'hbeef);
    $display("t_words done");
  endtask
  // One-byte control registers
  task automatic t_ctrl;
    cfgwd_host_inst.wr(8'h02, 40'h01, 1);
    chk(led, 1'b1);
    cfgwd_host_inst.wr(8'h05, 40'h03, 1);
    chk({m2, m1}, 2'b10);
    cfgwd_host_inst.wr(8'h05, 40'h01, 1);
    chk({m2, m1}, 2'b11);
    cfgwd_host_inst.wr(8'h05, 40'h02, 1);
    chk({m2, m1}, 2'b01);
    cfgwd_host_inst.wr(8'h02, 40'h00, 1);
    chk(led, 1'b0);
    cfgwd_host_inst.wr(8'h06, 40'h20, 1);
    chk({cfg, rw}, 9'h041);
    $display("t_ctrl done");
  endtask
  // Both reinit codes
  task automatic t_reinit;
    cfgwd_host_inst.wr(8'h01, 40'h01, 1);
    chk({rd, rk}, 2'b10);
    cfgwd_host_inst.wr(8'h01, 40'h00, 1);
    chk({rd, rk}, 2'b01);
    chk(st, 40'h12_3456_789a);
    $display("t_reinit done");
  endtask
  // Undefined command swallowed, next write resyncs
  task automatic t_unknown;
    cfgwd_host_inst.wr(8'h03, 40'hff_ffff_ffff, 5);
    chk(done, 1'b0);
    chk(st, 40'h12_3456_789a);
    cfgwd_host_inst.wr(8'h0c, 40'h00ff, 2);
    chk(pts, 40'h00ff);
    $display("t_unknown done");
  endtask
  // Enable low freezes pulses and drops a whole write
  task automatic t_freeze;
    cfgwd_host_inst.wr(8'h0b, 40'h0000_0007, 4);
    clkEn = 1'b0;
    repeat (2) @(negedge clk);
    chk({done, rep}, {1'b1, 32'h7});
    cfgwd_host_inst.wr(8'h0c, 40'h5555, 2);
    chk({done, pts}, {1'b1, 16'h00ff});
    clkEn = 1'b1;
    @(negedge clk);
    chk(done, 1'b0);
    $display("t_freeze done");
  endtask
  // Frame mark abandons a short write
  task automatic t_abort;
    cfgwd_host_inst.wr(8'h08, 40'h00_0000_aa55, 2);
    chk(done, 1'b0);
    cfgwd_host_inst.wr(8'h0c, 40'h1234, 2);
    chk(sp, 40'hfe_dcba_9876);
    chk({done, pts}, {1'b1, 16'h1234});
    $display("t_abort done");
  endtask
  // Reset in mid-run clears everything, then writes resume
  task automatic t_reset;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk(st | sp | inc, 40'h0);
    chk(hold | rep, 40'h0);
    chk({led, m2, m1, rw, cfg, rd, rk, done, pts}, 40'h0);
    cfgwd_host_inst.wr(8'h07, 40'h00_0000_0abc, 5);
    chk(st, 40'habc);
    $display("t_reset done");
  endtask
  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_freq;
    t_words;
    t_ctrl;
    t_reinit;
    t_unknown;
    t_freeze;
    t_abort;
    t_reset;
    summarize;
  end
  // Watchdog
  initial begin
    #200000;
    err_total++;
    summarize;
  end
endmodule // test_config_register_write_decoder
`default_nettype wire

// ===== common/cfgwd_defs.vh
// Function
// (RQ1) Configuration registers are write only; no readback path exists.
// (RQ2) Host sends only the needed data bytes, never padding to eight.
// (RQ3) Same address map and fields for every host link.
// (RQ4) First byte selects register; data byte count fixed per register.
// (RQ5) Start, stop, step frequencies are 40-bit hertz values from five bytes.
// (RQ6) Host sends address first, then data most significant byte first.
// (RQ7) Mode register bit 1 picks channel, bit 0 picks tone or sweep.
// (RQ8) Reinit 0x01 restores stored defaults; 0x00 resets keeping configuration.
// (RQ9) Sweep config bit 5 set rewinds to start after cycles complete.
// (RQ10) Unknown command bytes and their data are ignored, registers unchanged.
`ifndef CFGWD_DEFS_VH
`define CFGWD_DEFS_VH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define CFGWD_ADDR_REINIT     8'h01
`define CFGWD_ADDR_LED        8'h02
`define CFGWD_ADDR_MODE       8'h05
`define CFGWD_ADDR_SWEEPCFG   8'h06
`define CFGWD_ADDR_START      8'h07
`define CFGWD_ADDR_STOP       8'h08
`define CFGWD_ADDR_STEP       8'h09
`define CFGWD_ADDR_HOLD       8'h0a
`define CFGWD_ADDR_REPEAT     8'h0b
`define CFGWD_ADDR_POINTS     8'h0c

// ------------------------------------------------------------
// Data byte counts
// ------------------------------------------------------------
`define CFGWD_LEN_CTRL        3'h1
`define CFGWD_LEN_FREQ        3'h5
`define CFGWD_LEN_WORD        3'h4
`define CFGWD_LEN_POINTS      3'h2
`define CFGWD_LEN_UNKNOWN     3'h0

// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define CFGWD_MODE_SWEEP_BIT  0
`define CFGWD_MODE_CHAN_BIT   1
`define CFGWD_REWIND_BIT      5
`define CFGWD_LED_BIT         0
`define CFGWD_REINIT_DEFAULT  8'h01
`define CFGWD_REINIT_KEEP     8'h00

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CFGWD_RST_BYTE        8'h00
`define CFGWD_RST_FREQ        40'h00_0000_0000
`define CFGWD_RST_WORD        32'h0000_0000
`define CFGWD_RST_POINTS      16'h0000

`endif

// ===== logic/cfgwd_decoder.v
`include "cfgwd_defs.vh"
`default_nettype none

module cfgwd_decoder (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        clkEn,
  // Byte stream from link front end (same clock)
  input  wire        byteValid,
  input  wire [7:0]  byteData,
  input  wire        frameStart,
  // Re-initialise requests
  output reg         reinitDefaultPulse,
  output reg         reinitKeepPulse,
  // Decoded configuration
  output reg         activityLedOn,
  output reg         ch1SweepMode,
  output reg         ch2SweepMode,
  output reg  [7:0]  sweepBehaviourCfg,
  output reg         rewindAfterCycles,
  output reg  [39:0] sweepStartHz,
  output reg  [39:0] sweepStopHz,
  output reg  [39:0] sweepIncrementHz,
  output reg  [31:0] pointHoldTime,
  output reg  [31:0] sweepRepeatCount,
  output reg  [15:0] tablePointCount,
  output reg         writeDonePulse
);

  // ----------------------------------------------------------
  // Parser state
  // ----------------------------------------------------------
  // Waiting for a command byte, or collecting its data bytes
  localparam [0:0] ST_CMD  = 1'b0;
  localparam [0:0] ST_DATA = 1'b1;

  // Parser registers and their next values
  reg  [0:0]  state_reg;
  reg  [0:0]  state_next;
  reg  [7:0]  cmd_reg;
  reg  [7:0]  cmd_next;
  reg  [2:0]  left_reg;
  reg  [2:0]  left_next;
  reg  [39:0] shift_reg;
  reg  [39:0] shift_next;
  // Data byte count owed by the byte now seen as a command
  reg  [2:0]  len;

  // ----------------------------------------------------------
  // Byte classification
  // ----------------------------------------------------------
  // Nothing is taken while the enable is low
  wire        byteTaken = clkEn & byteValid;
  // Frame mark forces resync; an idle parser takes any byte as command
  wire        cmdByte   = byteTaken & (frameStart | (state_reg == ST_CMD));
  // Any other taken byte belongs to the write in progress
  wire        dataByte  = byteTaken & ~cmdByte;
  // Final data byte; unknown commands never reach a count of one
  wire        lastByte  = dataByte & (left_reg == 3'h1);

  // ----------------------------------------------------------
  // Register commit strobes
  // ----------------------------------------------------------
  // One strobe per register, raised with its final data byte
  wire        hitReinit = lastByte & (cmd_reg == `CFGWD_ADDR_REINIT);
  wire        hitLed    = lastByte & (cmd_reg == `CFGWD_ADDR_LED);
  wire        hitMode   = lastByte & (cmd_reg == `CFGWD_ADDR_MODE);
  wire        hitCfg    = lastByte & (cmd_reg == `CFGWD_ADDR_SWEEPCFG);
  wire        hitStart  = lastByte & (cmd_reg == `CFGWD_ADDR_START);
  wire        hitStop   = lastByte & (cmd_reg == `CFGWD_ADDR_STOP);
  wire        hitStep   = lastByte & (cmd_reg == `CFGWD_ADDR_STEP);
  wire        hitHold   = lastByte & (cmd_reg == `CFGWD_ADDR_HOLD);
  wire        hitRepeat = lastByte & (cmd_reg == `CFGWD_ADDR_REPEAT);
  wire        hitPoints = lastByte & (cmd_reg == `CFGWD_ADDR_POINTS);
  // Any strobe at all: a known register completes its write
  wire        hitAny    = hitReinit | hitLed | hitMode | hitCfg | hitStart | hitStop |
                          hitStep | hitHold | hitRepeat | hitPoints;

  // ----------------------------------------------------------
  // Command length decode
  // ----------------------------------------------------------
  // One table serves every host link, so the map cannot drift
  always @* begin
    case (byteData)  // [RQ4] [RQ3]
      `CFGWD_ADDR_REINIT, `CFGWD_ADDR_LED,
      `CFGWD_ADDR_MODE, `CFGWD_ADDR_SWEEPCFG:        len = `CFGWD_LEN_CTRL;
      `CFGWD_ADDR_START, `CFGWD_ADDR_STOP,
      `CFGWD_ADDR_STEP:                              len = `CFGWD_LEN_FREQ;
      `CFGWD_ADDR_HOLD, `CFGWD_ADDR_REPEAT:          len = `CFGWD_LEN_WORD;
      `CFGWD_ADDR_POINTS:                            len = `CFGWD_LEN_POINTS;
      default:                                       len = `CFGWD_LEN_UNKNOWN; // [RQ10]
    endcase
  end

  // ----------------------------------------------------------
  // Parser next state
  // ----------------------------------------------------------
  // Hold by default; a command byte restarts, a data byte shifts in
  always @* begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    left_next  = left_reg;
    shift_next = shift_reg;
    if (cmdByte) begin
      // A frame mark abandons any partial write
      state_next = ST_DATA;
      cmd_next   = byteData;                        // [RQ4]
      left_next  = len;
      shift_next = `CFGWD_RST_FREQ;
    end else if (dataByte) begin
      // Older bytes move up, so the last one lands in bits 7:0
      shift_next = {shift_reg[31:0], byteData};     // [RQ6] [RQ5]
      case (left_reg)
        3'h0: begin
          // Unknown command: swallow until the next frame mark
          left_next = 3'h0;                         // [RQ10]
        end
        3'h1: begin
          left_next  = 3'h0;
          state_next = ST_CMD;
        end
        default: begin
          left_next = left_reg - 3'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Parser registers
  // ----------------------------------------------------------
  // Enable low freezes the parser in mid-write
  always @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_CMD;
      cmd_reg   <= `CFGWD_RST_BYTE;
      left_reg  <= 3'h0;
      shift_reg <= `CFGWD_RST_FREQ;
    end else if (clkEn) begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      left_reg  <= left_next;
      shift_reg <= shift_next;
    end
  end

  // ----------------------------------------------------------
  // Request pulses
  // ----------------------------------------------------------
  // One-cycle pulses, cleared on the next enabled edge
  always @(posedge clk) begin
    if (sys_rst) begin
      reinitDefaultPulse <= 1'b0;
      reinitKeepPulse    <= 1'b0;
      writeDonePulse     <= 1'b0;
    end else if (clkEn) begin
      // Other reinit values complete the write but request nothing
      reinitDefaultPulse <= hitReinit & (byteData == `CFGWD_REINIT_DEFAULT); // [RQ8]
      reinitKeepPulse    <= hitReinit & (byteData == `CFGWD_REINIT_KEEP);    // [RQ8]
      writeDonePulse     <= hitAny;                                           // [RQ4]
    end
  end

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  // One-byte registers take the final byte directly
  always @(posedge clk) begin
    if (sys_rst) begin
      activityLedOn     <= 1'b0;
      ch1SweepMode      <= 1'b0;
      ch2SweepMode      <= 1'b0;
      sweepBehaviourCfg <= `CFGWD_RST_BYTE;
      rewindAfterCycles <= 1'b0;
    end else if (clkEn) begin
      if (hitLed) begin
        activityLedOn <= byteData[`CFGWD_LED_BIT];
      end
      // Channel bit steers the tone/sweep bit to one channel only
      if (hitMode && byteData[`CFGWD_MODE_CHAN_BIT]) begin   // [RQ7]
        ch2SweepMode <= byteData[`CFGWD_MODE_SWEEP_BIT];
      end
      if (hitMode && !byteData[`CFGWD_MODE_CHAN_BIT]) begin  // [RQ7]
        ch1SweepMode <= byteData[`CFGWD_MODE_SWEEP_BIT];
      end
      if (hitCfg) begin
        sweepBehaviourCfg <= byteData;
        rewindAfterCycles <= byteData[`CFGWD_REWIND_BIT];    // [RQ9]
      end
    end
  end

  // ----------------------------------------------------------
  // Frequency words
  // ----------------------------------------------------------
  // Full 40-bit assembly including the byte now arriving
  always @(posedge clk) begin
    if (sys_rst) begin
      sweepStartHz     <= `CFGWD_RST_FREQ;
      sweepStopHz      <= `CFGWD_RST_FREQ;
      sweepIncrementHz <= `CFGWD_RST_FREQ;
    end else if (clkEn) begin
      if (hitStart) begin
        sweepStartHz <= shift_next;                          // [RQ5]
      end
      if (hitStop) begin
        sweepStopHz <= shift_next;                           // [RQ5]
      end
      if (hitStep) begin
        sweepIncrementHz <= shift_next;                      // [RQ5]
      end
    end
  end

  // ----------------------------------------------------------
  // Timing and count words
  // ----------------------------------------------------------
  // Shorter words keep only the low bytes of the assembly
  always @(posedge clk) begin
    if (sys_rst) begin
      pointHoldTime    <= `CFGWD_RST_WORD;
      sweepRepeatCount <= `CFGWD_RST_WORD;
      tablePointCount  <= `CFGWD_RST_POINTS;
    end else if (clkEn) begin
      if (hitHold) begin
        pointHoldTime <= shift_next[31:0];                   // [RQ4]
      end
      if (hitRepeat) begin
        sweepRepeatCount <= shift_next[31:0];                // [RQ4]
      end
      if (hitPoints) begin
        tablePointCount <= shift_next[15:0];                 // [RQ4]
      end
    end
  end

  // Registers are outputs only; no readback path exists [RQ1]

endmodule // cfgwd_decoder
`default_nettype wire
